// ===== src/mbx_defines.svh
// Constants of the mailbox unit: selectors, field positions, reset values
`ifndef MBX_DEFINES_SVH
`define MBX_DEFINES_SVH

// ********************************************************************
// Access selectors
// ********************************************************************
`define MBX_SEL_OWNER      4'h0
`define MBX_SEL_TGT        4'h1
`define MBX_SEL_TGT_SET    4'h2
`define MBX_SEL_TGT_CLR    4'h3
`define MBX_SEL_MASK       4'h4
`define MBX_SEL_MASK_SET   4'h5
`define MBX_SEL_MASK_CLR   4'h6
`define MBX_SEL_SEND       4'h7
`define MBX_SEL_MODE       4'h8
`define MBX_SEL_DATA       4'h9
`define MBX_SEL_RAW        4'ha
`define MBX_SEL_MASKED     4'hb
`define MBX_SEL_CONFIG     4'hc

// ********************************************************************
// Field positions
// ********************************************************************
`define MBX_SEND_DST_BIT   0
`define MBX_SEND_ACK_BIT   1
`define MBX_MODE_AUTO_BIT  0
`define MBX_MODE_LINK_BIT  1
`define MBX_CFG_MBOX_LSB   0
`define MBX_CFG_DATA_LSB   8
`define MBX_CFG_INT_LSB    16

// ********************************************************************
// Sizes and reset values
// ********************************************************************
`define MBX_MAX_MBOX       32
`define MBX_MAX_CHAN       32
`define MBX_MAX_WORDS      7
`define MBX_SEND_IDLE      2'h0
`define MBX_SEND_MSG       2'h1
`define MBX_SEND_ACK       2'h2
`define MBX_SEND_BAD       2'h3
`define MBX_WORD_RST       32'h0000_0000

`endif

// ===== src/mbx_pkg.sv
// Types shared by the mailbox unit
package mbx_pkg;
   typedef logic [31:0]        mbx_word_t;
   typedef logic [31:0][31:0]  mbx_mtx_t;
   typedef logic [3:0]         mbx_sel_t;
   typedef logic [1:0]         mbx_pair_t;
   typedef logic [5:0]         mbx_count_t;
   typedef logic [2:0]         mbx_wcount_t;
endpackage

// ===== src/mbx_irq_merge.sv
// Status matrices and per-channel interrupt lines of the mailbox unit
`timescale 1ns/10ps
`include "mbx_defines.svh"

module mbx_irq_merge (
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   input  wire mbx_pkg::mbx_mtx_t owner_mtx,
   input  wire mbx_pkg::mbx_mtx_t target_mtx,
   input  wire mbx_pkg::mbx_mtx_t mask_mtx,
   input  wire mbx_pkg::mbx_word_t send_dst,
   input  wire mbx_pkg::mbx_word_t send_ack,
   input  wire mbx_pkg::mbx_word_t mbox_valid,
   input  wire mbx_pkg::mbx_word_t chan_valid,
   output mbx_pkg::mbx_mtx_t      raw_mtx,
   output mbx_pkg::mbx_mtx_t      masked_mtx,
   output mbx_pkg::mbx_word_t     irq_r
);
   import mbx_pkg::*;

   mbx_word_t irq_nxt;

   // ********************************************************************
   // Status per channel, one bit per mailbox
   // ********************************************************************
   always_comb begin
      raw_mtx    = '0;
      masked_mtx = '0;
      irq_nxt    = '0;
      for (int c = 0; c < `MBX_MAX_CHAN; c++) begin
         for (int m = 0; m < `MBX_MAX_MBOX; m++) begin
            raw_mtx[c][m] = mbox_valid[m] & chan_valid[c] &
                            ((send_dst[m] & target_mtx[m][c]) |
                             (send_ack[m] & owner_mtx[m][c]));
            masked_mtx[c][m] = raw_mtx[c][m] & mask_mtx[m][c];
         end
         irq_nxt[c] = |masked_mtx[c];
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq_r <= '0;
      end else begin
         irq_r <= irq_nxt;
      end
   end
endmodule

// ===== src/mbx_core.sv
// Mailbox unit: ownership, targets, masks, send, mode, payload and access port
// ********************************************************************
// ********************************************************************
`timescale 1ns/10ps
`include "mbx_defines.svh"

module mbx_core (
   input  wire logic               mclk,
   input  wire logic               sys_rst,
   input  wire mbx_pkg::mbx_count_t  mailbox_count_tie,
   input  wire mbx_pkg::mbx_count_t  irq_channel_count_tie,
   input  wire mbx_pkg::mbx_wcount_t payload_word_count_tie,
   input  wire logic               acc_wr,
   input  wire logic               acc_rd,
   input  wire logic [4:0]         acc_index,
   input  wire mbx_pkg::mbx_sel_t  acc_sel,
   input  wire logic [2:0]         acc_word,
   input  wire mbx_pkg::mbx_word_t acc_wdata,
   output mbx_pkg::mbx_word_t      acc_rdata_r,
   output logic                    acc_rvalid_r,
   output mbx_pkg::mbx_word_t      channel_irq_out
);
   import mbx_pkg::*;

   // ********************************************************************
   // State
   // ********************************************************************
   mbx_mtx_t  owner_r;
   mbx_mtx_t  owner_nxt;
   mbx_mtx_t  target_r;
   mbx_mtx_t  target_nxt;
   mbx_mtx_t  mask_r;
   mbx_mtx_t  mask_nxt;
   mbx_pair_t send_r  [`MBX_MAX_MBOX];
   mbx_pair_t send_nxt[`MBX_MAX_MBOX];
   mbx_pair_t mode_r  [`MBX_MAX_MBOX];
   mbx_pair_t mode_nxt[`MBX_MAX_MBOX];
   mbx_word_t data_r  [`MBX_MAX_MBOX][`MBX_MAX_WORDS];
   mbx_word_t data_nxt[`MBX_MAX_MBOX][`MBX_MAX_WORDS];
   mbx_word_t rdata_nxt;
   logic      rvalid_nxt;

   mbx_word_t mbox_valid;
   mbx_word_t chan_valid;
   mbx_word_t send_dst;
   mbx_word_t send_ack;
   mbx_mtx_t  raw_mtx;
   mbx_mtx_t  masked_mtx;

   // Low n bits set, for the tie-off counts
   function automatic mbx_word_t count_mask(input mbx_count_t n);
      mbx_word_t r;
      r = '0;
      for (int i = 0; i < 32; i++) begin
         r[i] = (i < n);
      end
      return r;
   endfunction

   // ********************************************************************
   // Configuration
   // ********************************************************************
   always_comb begin
      mbox_valid = count_mask(mailbox_count_tie);
      chan_valid = count_mask(irq_channel_count_tie);
   end

   // ********************************************************************
   // Interrupt source vectors
   // ********************************************************************
   always_comb begin
      for (int m = 0; m < `MBX_MAX_MBOX; m++) begin
         send_dst[m] = send_r[m][`MBX_SEND_DST_BIT];
         // A linked mailbox hands its acknowledge to the next one instead
         send_ack[m] = send_r[m][`MBX_SEND_ACK_BIT] & ~mode_r[m][`MBX_MODE_LINK_BIT];
      end
   end

   // ********************************************************************
   // Mailbox state next values
   // ********************************************************************
   always_comb begin
      logic      owned;
      logic      ok;
      mbx_word_t ack_ev;
      owned = 1'b0;
      ok = 1'b0;
      ack_ev = '0;
      owner_nxt  = owner_r;
      target_nxt = target_r;
      mask_nxt   = mask_r;
      send_nxt   = send_r;
      mode_nxt   = mode_r;
      data_nxt   = data_r;

      // Out-of-range mailboxes take no writes
      ok    = mbox_valid[acc_index];
      owned = (owner_r[acc_index] != '0);
      if (acc_wr && ok) begin
         case (acc_sel)
            `MBX_SEL_OWNER: begin
               if (!owned) begin
                  owner_nxt[acc_index] = acc_wdata & chan_valid;
               end else if (acc_wdata == '0) begin
                  // Release wipes the whole mailbox
                  owner_nxt[acc_index]  = '0;
                  target_nxt[acc_index] = '0;
                  mask_nxt[acc_index]   = '0;
                  send_nxt[acc_index]   = `MBX_SEND_IDLE;
                  mode_nxt[acc_index]   = `MBX_SEND_IDLE;
                  for (int w = 0; w < `MBX_MAX_WORDS; w++) begin
                     data_nxt[acc_index][w] = `MBX_WORD_RST;
                  end
               end
            end
            `MBX_SEL_TGT_SET: begin
               if (owned) begin
                  target_nxt[acc_index] = target_r[acc_index] | (acc_wdata & chan_valid);
               end
            end
            `MBX_SEL_TGT_CLR: begin
               if (owned) begin
                  target_nxt[acc_index] = target_r[acc_index] & ~acc_wdata;
               end
            end
            `MBX_SEL_MASK_SET: begin
               if (owned) begin
                  mask_nxt[acc_index] = mask_r[acc_index] | (acc_wdata & chan_valid);
               end
            end
            `MBX_SEL_MASK_CLR: begin
               if (owned) begin
                  mask_nxt[acc_index] = mask_r[acc_index] & ~acc_wdata;
               end
            end
            `MBX_SEL_SEND: begin
               // Value 11 is refused and leaves the register as it was
               if (owned && acc_wdata[1:0] != `MBX_SEND_BAD) begin
                  send_nxt[acc_index] = acc_wdata[1:0];
               end
            end
            `MBX_SEL_MODE: begin
               if (owned) begin
                  mode_nxt[acc_index] = acc_wdata[1:0];
               end
            end
            `MBX_SEL_DATA: begin
               if (owned && acc_word < payload_word_count_tie) begin
                  data_nxt[acc_index][acc_word] = acc_wdata;
               end
            end
            default: begin
            end
         endcase
      end

      // Auto acknowledge once every destination has cleared its target bit
      for (int m = 0; m < `MBX_MAX_MBOX; m++) begin
         if (mode_nxt[m][`MBX_MODE_AUTO_BIT] && send_nxt[m] == `MBX_SEND_MSG &&
             target_nxt[m] == '0 && owner_nxt[m] != '0) begin
            send_nxt[m] = `MBX_SEND_ACK;
         end
         ack_ev[m] = (send_nxt[m] == `MBX_SEND_ACK) && (send_r[m] != `MBX_SEND_ACK);
      end

      // Acknowledge of a linked mailbox sends the next mailbox's message
      // A busy or unowned next mailbox is left alone
      for (int m = 0; m < `MBX_MAX_MBOX - 1; m++) begin
         if (ack_ev[m] && mode_nxt[m][`MBX_MODE_LINK_BIT] && mbox_valid[m + 1] &&
             owner_nxt[m + 1] != '0 && send_nxt[m + 1] == `MBX_SEND_IDLE) begin
            send_nxt[m + 1] = `MBX_SEND_MSG;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         owner_r  <= '0;
         target_r <= '0;
         mask_r   <= '0;
         for (int m = 0; m < `MBX_MAX_MBOX; m++) begin
            send_r[m] <= `MBX_SEND_IDLE;
            mode_r[m] <= `MBX_SEND_IDLE;
            for (int w = 0; w < `MBX_MAX_WORDS; w++) begin
               data_r[m][w] <= `MBX_WORD_RST;
            end
         end
      end else begin
         owner_r  <= owner_nxt;
         target_r <= target_nxt;
         mask_r   <= mask_nxt;
         send_r   <= send_nxt;
         mode_r   <= mode_nxt;
         data_r   <= data_nxt;
      end
   end

   // ********************************************************************
   // Read path
   // ********************************************************************
   always_comb begin
      logic ok;
      // A read beside a write sees the old state
      ok = mbox_valid[acc_index];
      rvalid_nxt = acc_rd;
      rdata_nxt  = '0;
      if (acc_rd) begin
         case (acc_sel)
            `MBX_SEL_OWNER: begin
               rdata_nxt = ok ? owner_r[acc_index] : '0;
            end
            `MBX_SEL_TGT, `MBX_SEL_TGT_SET, `MBX_SEL_TGT_CLR: begin
               rdata_nxt = ok ? target_r[acc_index] : '0;
            end
            `MBX_SEL_MASK, `MBX_SEL_MASK_SET, `MBX_SEL_MASK_CLR: begin
               rdata_nxt = ok ? mask_r[acc_index] : '0;
            end
            `MBX_SEL_SEND: begin
               rdata_nxt = ok ? {30'h0000_0000, send_r[acc_index]} : '0;
            end
            `MBX_SEL_MODE: begin
               rdata_nxt = ok ? {30'h0000_0000, mode_r[acc_index]} : '0;
            end
            `MBX_SEL_DATA: begin
               if (ok && acc_word < payload_word_count_tie) begin
                  rdata_nxt = data_r[acc_index][acc_word];
               end
            end
            `MBX_SEL_RAW: begin
               // Index selects the channel here
               rdata_nxt = chan_valid[acc_index] ? raw_mtx[acc_index] : '0;
            end
            `MBX_SEL_MASKED: begin
               rdata_nxt = chan_valid[acc_index] ? masked_mtx[acc_index] : '0;
            end
            `MBX_SEL_CONFIG: begin
               rdata_nxt[`MBX_CFG_MBOX_LSB +: 6] = mailbox_count_tie;
               rdata_nxt[`MBX_CFG_DATA_LSB +: 3] = payload_word_count_tie;
               rdata_nxt[`MBX_CFG_INT_LSB +: 6]  = irq_channel_count_tie;
            end
            default: begin
               rdata_nxt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         acc_rdata_r  <= '0;
         acc_rvalid_r <= 1'b0;
      end else begin
         acc_rdata_r  <= rdata_nxt;
         acc_rvalid_r <= rvalid_nxt;
      end
   end

   // ********************************************************************
   // Status and interrupt lines
   // ********************************************************************
   // Lines follow a write by two edges
   mbx_irq_merge u_irq (
      .mclk       (mclk),
      .sys_rst    (sys_rst),
      .owner_mtx  (owner_r),
      .target_mtx (target_r),
      .mask_mtx   (mask_r),
      .send_dst   (send_dst),
      .send_ack   (send_ack),
      .mbox_valid (mbox_valid),
      .chan_valid (chan_valid),
      .raw_mtx    (raw_mtx),
      .masked_mtx (masked_mtx),
      .irq_r      (channel_irq_out)
   );
endmodule

// ===== tb/mbx_core_props.sv
// Checker of the mailbox unit access port and interrupt lines
`timescale 1ns/10ps
module mbx_core_props (
   input wire logic                 mclk,
   input wire logic                 sys_rst,
   input wire mbx_pkg::mbx_count_t  mailbox_count_tie,
   input wire mbx_pkg::mbx_count_t  irq_channel_count_tie,
   input wire mbx_pkg::mbx_wcount_t payload_word_count_tie,
   input wire logic                 acc_wr,
   input wire logic                 acc_rd,
   input wire mbx_pkg::mbx_sel_t    acc_sel,
   input wire mbx_pkg::mbx_word_t   acc_rdata_r,
   input wire logic                 acc_rvalid_r,
   input wire mbx_pkg::mbx_word_t   channel_irq_out
);
   import mbx_pkg::*;
   // ****************************************************
   // Valid masks
   // ****************************************************
   wire logic [32:0] chan_ok = (33'h1 << irq_channel_count_tie) - 33'h1;
   wire logic [32:0] mbox_ok = (33'h1 << mailbox_count_tie) - 33'h1;
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // ****************************************************
   // Assertions
   // ****************************************************
   AST_RVALID: assert property (acc_rd |=> acc_rvalid_r)
      else $error("read got no valid strobe");
   AST_RV_IDLE: assert property (!acc_rd |=> !acc_rvalid_r)
      else $error("valid strobe without a read");
   AST_RD_ZERO: assert property (!acc_rvalid_r |-> acc_rdata_r == 32'h0)
      else $error("read data not zero while idle");
   AST_CFG: assert property (acc_rd && acc_sel == 4'hc |=> acc_rdata_r ==
      {10'h0, irq_channel_count_tie, 5'h0, payload_word_count_tie, 2'h0, mailbox_count_tie})
      else $error("configuration word wrong");
   AST_CHAN_RANGE: assert property ((channel_irq_out & ~chan_ok[31:0]) == 32'h0)
      else $error("interrupt beyond channel count");
   AST_RAW_RANGE: assert property (acc_rd && acc_sel == 4'ha |=>
      (acc_rdata_r & ~mbox_ok[31:0]) == 32'h0) else $error("status beyond mailbox count");
   AST_MASK_RANGE: assert property (acc_rd && acc_sel == 4'h4 |=>
      (acc_rdata_r & ~chan_ok[31:0]) == 32'h0) else $error("enable beyond channel count");
   AST_IRQ_STABLE: assert property (!acc_wr ##1 !acc_wr |=> $stable(channel_irq_out))
      else $error("interrupt moved without a write");
   AST_COV_IRQ: cover property (channel_irq_out != 32'h0);
   AST_COV_RAW: cover property (acc_rd && acc_sel == 4'ha ##1 acc_rdata_r != 32'h0);
   AST_COV_CFG: cover property (acc_rd && acc_sel == 4'hc);
endmodule

bind mbx_core mbx_core_props chk (.mclk, .sys_rst, .mailbox_count_tie, .irq_channel_count_tie,
   .payload_word_count_tie, .acc_wr, .acc_rd, .acc_sel, .acc_rdata_r, .acc_rvalid_r, .channel_irq_out);

// ===== tb/mbx_cores_model.sv
// Model of the cores sharing the mailbox access port
`timescale 1ns/10ps
module mbx_cores_model (
   input  wire logic               mclk,
   input  wire mbx_pkg::mbx_word_t acc_rdata_r,
   output logic                    acc_wr,
   output logic                    acc_rd,
   output logic [4:0]              acc_index,
   output mbx_pkg::mbx_sel_t       acc_sel,
   output logic [2:0]              acc_word,
   output mbx_pkg::mbx_word_t      acc_wdata
);
   import mbx_pkg::*;
   initial begin
      {acc_wr, acc_rd, acc_index, acc_sel, acc_word, acc_wdata} = '0;
   end
   // ****************************************************
   // One access, launched on a falling edge
   // ****************************************************
   task automatic wr(input logic [4:0] i, input mbx_sel_t s, input logic [2:0] w, input mbx_word_t d);
      @(negedge mclk);
      {acc_index, acc_sel, acc_word, acc_wdata} = {i, s, w, d};
      acc_wr = 1'b1;
      @(negedge mclk);
      acc_wr    = 1'b0;
      acc_wdata = ~d;
   endtask
   task automatic rd(input logic [4:0] i, input mbx_sel_t s, input logic [2:0] w, output mbx_word_t q);
      @(negedge mclk);
      {acc_index, acc_sel, acc_word} = {i, s, w};
      acc_rd = 1'b1;
      @(negedge mclk);
      acc_rd = 1'b0;
      q      = acc_rdata_r;
   endtask
endmodule

// ===== tb/mbx_core_tb.sv
// Testbench of the mailbox unit
`timescale 1ns/10ps
`include "mbx_defines.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
   $display("wrong value at %0t ns: got %h, expected %h", $time, a, b); end end
module mbx_core_tb;
   import mbx_pkg::*;
   logic        mclk, sys_rst, acc_wr, acc_rd;
   mbx_count_t  mbox_n, chan_n;
   mbx_wcount_t word_n;
   logic [4:0]  acc_index;
   logic [2:0]  acc_word;
   mbx_sel_t    acc_sel;
   mbx_word_t   acc_wdata, acc_rdata_r, channel_irq_out;
   logic        acc_rvalid_r;
   int          n_errors = 0;
   int          n_tests = 0;
   mbx_core uut (.mclk(mclk), .sys_rst(sys_rst), .mailbox_count_tie(mbox_n), .irq_channel_count_tie(chan_n),
      .payload_word_count_tie(word_n), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_index(acc_index),
      .acc_sel(acc_sel), .acc_word(acc_word), .acc_wdata(acc_wdata), .acc_rdata_r(acc_rdata_r),
      .acc_rvalid_r(acc_rvalid_r), .channel_irq_out(channel_irq_out));
   mbx_cores_model cores (.mclk(mclk), .acc_rdata_r(acc_rdata_r), .acc_wr(acc_wr), .acc_rd(acc_rd),
      .acc_index(acc_index), .acc_sel(acc_sel), .acc_word(acc_word), .acc_wdata(acc_wdata));
   // ****************************************************
   // Clock, reset and helpers
   // ****************************************************
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic do_reset(input mbx_count_t m, input mbx_count_t c, input mbx_wcount_t w);
      {mbox_n, chan_n, word_n, sys_rst} = {m, c, w, 1'b1};
      repeat (3) @(negedge mclk);
      sys_rst = 1'b0;
   endtask
   task automatic wr(input logic [4:0] i, input mbx_sel_t s, input mbx_word_t d);
      cores.wr(i, s, 3'h0, d);
   endtask
   task automatic chk(input logic [4:0] i, input mbx_sel_t s, input logic [2:0] w, input mbx_word_t e);
      mbx_word_t q;
      cores.rd(i, s, w, q);
      `CHK(q, e)
      `CHK(acc_rvalid_r, 1'b1)
   endtask
   task automatic print_verdict;
      $display("tests %0d, errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #2000000;
      n_errors++;
      print_verdict;
   end
   // ****************************************************
   // Tests
   // ****************************************************
   initial begin
      do_reset(6'h04, 6'h04, 3'h1);
      chk(5'h0, `MBX_SEL_CONFIG, 3'h0, 32'h0004_0104);
      wr(5'h0, `MBX_SEL_SEND, 32'h1);
      chk(5'h0, `MBX_SEL_SEND, 3'h0, 32'h0);
      wr(5'h0, `MBX_SEL_OWNER, 32'h1);
      wr(5'h0, `MBX_SEL_OWNER, 32'h2);
      chk(5'h0, `MBX_SEL_OWNER, 3'h0, 32'h1);
      wr(5'h0, `MBX_SEL_MASK_SET, 32'h13);
      chk(5'h0, `MBX_SEL_MASK, 3'h0, 32'h3);
      wr(5'h0, `MBX_SEL_TGT_SET, 32'h2);
      wr(5'h0, `MBX_SEL_DATA, 32'hda7a_0000);
      cores.wr(5'h0, `MBX_SEL_DATA, 3'h1, 32'h5);
      chk(5'h0, `MBX_SEL_DATA, 3'h1, 32'h0);
      chk(5'h0, `MBX_SEL_DATA, 3'h0, 32'hda7a_0000);
      wr(5'h0, `MBX_SEL_SEND, 32'h1);
      chk(5'h1, `MBX_SEL_RAW, 3'h0, 32'h1);
      `CHK(channel_irq_out, 32'h2)
      wr(5'h0, `MBX_SEL_DATA, 32'hda7a_1111);
      wr(5'h0, `MBX_SEL_SEND, 32'h2);
      chk(5'h1, `MBX_SEL_RAW, 3'h0, 32'h0);
      chk(5'h0, `MBX_SEL_RAW, 3'h0, 32'h1);
      `CHK(channel_irq_out, 32'h1)
      wr(5'h0, `MBX_SEL_MASK_CLR, 32'h1);
      chk(5'h0, `MBX_SEL_DATA, 3'h0, 32'hda7a_1111);
      `CHK(channel_irq_out, 32'h0)
      wr(5'h0, `MBX_SEL_SEND, 32'h0);
      wr(5'h0, `MBX_SEL_SEND, 32'h3);
      chk(5'h0, `MBX_SEL_SEND, 3'h0, 32'h0);
      wr(5'h0, `MBX_SEL_OWNER, 32'h0);
      chk(5'h0, `MBX_SEL_TGT, 3'h0, 32'h0);
      chk(5'h0, `MBX_SEL_MASK, 3'h0, 32'h0);
      chk(5'h0, `MBX_SEL_DATA, 3'h0, 32'h0);
      wr(5'h5, `MBX_SEL_OWNER, 32'h1);
      chk(5'h5, `MBX_SEL_OWNER, 3'h0, 32'h0);
      // Multicast with automatic acknowledge
      wr(5'h0, `MBX_SEL_OWNER, 32'h1);
      wr(5'h0, `MBX_SEL_MODE, 32'h1);
      wr(5'h0, `MBX_SEL_MASK_SET, 32'hf);
      wr(5'h0, `MBX_SEL_TGT_SET, 32'he);
      wr(5'h0, `MBX_SEL_DATA, 32'h1234_5678);
      wr(5'h0, `MBX_SEL_SEND, 32'h1);
      wr(5'h0, `MBX_SEL_TGT_CLR, 32'h2);
      wr(5'h0, `MBX_SEL_TGT_CLR, 32'h8);
      chk(5'h0, `MBX_SEL_SEND, 3'h0, 32'h1);
      `CHK(channel_irq_out, 32'h4)
      wr(5'h0, `MBX_SEL_TGT_CLR, 32'h4);
      chk(5'h0, `MBX_SEL_SEND, 3'h0, 32'h2);
      `CHK(channel_irq_out, 32'h1)
      chk(5'h0, `MBX_SEL_DATA, 3'h0, 32'h1234_5678);
      wr(5'h0, `MBX_SEL_SEND, 32'h0);
      chk(5'h0, `MBX_SEL_OWNER, 3'h0, 32'h1);
      // Two chained mailboxes, manual acknowledge
      wr(5'h0, `MBX_SEL_MODE, 32'h2);
      wr(5'h0, `MBX_SEL_TGT_SET, 32'h2);
      wr(5'h1, `MBX_SEL_OWNER, 32'h1);
      wr(5'h1, `MBX_SEL_MASK_SET, 32'h3);
      wr(5'h1, `MBX_SEL_TGT_SET, 32'h2);
      wr(5'h0, `MBX_SEL_SEND, 32'h1);
      wr(5'h0, `MBX_SEL_SEND, 32'h2);
      chk(5'h1, `MBX_SEL_SEND, 3'h0, 32'h1);
      chk(5'h0, `MBX_SEL_RAW, 3'h0, 32'h0);
      chk(5'h1, `MBX_SEL_RAW, 3'h0, 32'h2);
      wr(5'h1, `MBX_SEL_SEND, 32'h2);
      chk(5'h0, `MBX_SEL_RAW, 3'h0, 32'h2);
      `CHK(channel_irq_out, 32'h1)
      // Two chained mailboxes, automatic acknowledge
      wr(5'h0, `MBX_SEL_SEND, 32'h0);
      wr(5'h1, `MBX_SEL_SEND, 32'h0);
      wr(5'h0, `MBX_SEL_MODE, 32'h3);
      wr(5'h0, `MBX_SEL_SEND, 32'h1);
      wr(5'h0, `MBX_SEL_TGT_CLR, 32'h2);
      chk(5'h0, `MBX_SEL_SEND, 3'h0, 32'h2);
      chk(5'h1, `MBX_SEL_SEND, 3'h0, 32'h1);
      chk(5'h1, `MBX_SEL_RAW, 3'h0, 32'h2);
      `CHK(channel_irq_out, 32'h2)
      // Largest configuration after a second reset
      do_reset(6'h20, 6'h20, 3'h7);
      chk(5'h0, `MBX_SEL_CONFIG, 3'h0, 32'h0020_0720);
      chk(5'h0, `MBX_SEL_OWNER, 3'h0, 32'h0);
      wr(5'h1f, `MBX_SEL_OWNER, 32'h8000_0000);
      wr(5'h1f, `MBX_SEL_MASK_SET, 32'h8000_0000);
      wr(5'h1f, `MBX_SEL_TGT_SET, 32'h8000_0000);
      cores.wr(5'h1f, `MBX_SEL_DATA, 3'h6, 32'hcafe_0006);
      chk(5'h1f, `MBX_SEL_DATA, 3'h6, 32'hcafe_0006);
      wr(5'h1f, `MBX_SEL_SEND, 32'h1);
      chk(5'h1f, `MBX_SEL_RAW, 3'h0, 32'h8000_0000);
      `CHK(channel_irq_out, 32'h8000_0000)
      print_verdict;
   end
endmodule
